// >>> rtl/hat_gap_rules.sv
// required idle gaps before the next read, by target and history
`default_nettype none
`include "hat_map.svh"
module hat_gap_rules (
    input  wire hat_pkg::hat_target_t i_target,
    input  wire hat_pkg::hat_target_t i_last_read,
    input  wire logic                 i_ffwd_guard,
    output logic [7:0]                o_write_gap,
    output logic [7:0]                o_read_gap
);
    import hat_pkg::*;

    localparam logic [7:0] GAP1 = 8'(`HAT_CYC_GAP1);
    localparam logic [7:0] GAP2 = 8'(`HAT_CYC_GAP2);

    always_comb begin
        case (i_target)
            T_IDENTITY_REVISION_REG, T_BYTE_TEST, T_RX_LVL, T_RX_DROP,
            T_RX_DATA, T_RX_STATUS, T_TX_STATUS, T_TX_DATA: o_write_gap = 8'h00;
            T_SLOW:  o_write_gap = GAP2;
            default: o_write_gap = GAP1;
        endcase
    end

    always_comb begin
        o_read_gap = 8'h00;
        if (i_target == T_RX_LVL && (i_last_read == T_RX_DATA || i_last_read == T_RX_STATUS)) begin
            o_read_gap = GAP1;
        end
        if (i_target == T_TX_LVL && i_last_read == T_TX_STATUS) begin
            o_read_gap = GAP1;
        end
        if (i_target == T_RX_DROP && i_last_read == T_RX_DROP) begin
            o_read_gap = GAP2;
        end
        if (i_ffwd_guard && i_last_read == T_RECEIVE_DATAPATH_CONTROL_REG &&
            (i_target == T_TX_STATUS || i_target == T_RX_STATUS)) begin
            o_read_gap = GAP2;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/hat_host.sv
// host-side sequencer for the 16-bit parallel port, with an APB register slave
//
// The placing of the registers and the APB register port were decided locally.
`default_nettype none
`include "hat_map.svh"
module hat_host #(
    parameter logic [6:0] BYTE_TEST_ADDR = 7'h00
) (
    input  wire logic              i_clock,
    input  wire logic              i_arst_n,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [11:0]       i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    output var hat_pkg::hat_pins_t o_pins,
    output logic      [15:0]       o_data,
    output logic                   o_data_oe_n,
    input  wire logic [15:0]       i_data
);
    import hat_pkg::*;

    localparam logic [5:0] ASSERT_CYC  = 6'(`HAT_CYC_ASSERT);
    localparam logic [5:0] RECOVER_CYC = 6'(`HAT_CYC_RECOVER);
    localparam logic [7:0] GAP1        = 8'(`HAT_CYC_GAP1);
    localparam logic [7:0] GAP2        = 8'(`HAT_CYC_GAP2);
    localparam hat_pins_t  PINS_IDLE   = '{device_select_low: 1'b1, read_strobe_low: 1'b1,
                                           write_strobe_low: 1'b1, fifo_select: 1'b0,
                                           addr: 7'h00};

    hat_state_t  state;
    hat_cmd_t    cmd;
    hat_pins_t   pins;
    hat_target_t last_read;
    logic [1:0]  ctrl;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [5:0]  cnt;
    logic [7:0]  since_write;
    logic [7:0]  since_read;
    logic [7:0]  write_gap;
    logic [7:0]  read_gap;
    logic [7:0]  dummy_cnt;
    logic        dummy;
    logic        done;
    logic        err;
    logic        apb_wr;
    logic        hit;
    logic        start;
    logic        gap_met;
    logic        strobe_end;
    logic        recover_end;

    assign apb_wr      = i_psel && i_penable && i_pwrite;
    assign start       = apb_wr && i_paddr == `HAT_CMD_OFS && state == S_IDLE;
    assign strobe_end  = state == S_STROBE && cnt == ASSERT_CYC - 6'h01;
    assign recover_end = state == S_RECOVER && cnt == RECOVER_CYC - 6'h01;
    assign o_pins      = pins;

    hat_gap_rules u_gap (
        .i_target    (cmd.target),
        .i_last_read (last_read),
        .i_ffwd_guard(ctrl[`HAT_CTRL_FFWD_BIT]),
        .o_write_gap (write_gap),
        .o_read_gap  (read_gap)
    );

    assign gap_met = since_write >= write_gap && since_read >= read_gap;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl <= `HAT_CTRL_RST;
        end else if (apb_wr && i_paddr == `HAT_CTRL_OFS) begin
            ctrl <= i_pwdata[1:0];
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wdata <= 16'h0000;
        end else if (apb_wr && i_paddr == `HAT_WDATA_OFS) begin
            wdata <= i_pwdata[15:0];
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cmd <= '0;
        end else if (start) begin
            cmd <= hat_cmd_t'(i_pwdata[12:0]);
        end
    end

    // sticky flags, set wins over clear
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            done <= 1'b0;
            err  <= 1'b0;
        end else begin
            if (recover_end && !dummy) begin
                done <= 1'b1;
            end else if (start || (apb_wr && i_paddr == `HAT_STATUS_OFS &&
                                   i_pwdata[`HAT_STAT_DONE_BIT])) begin
                done <= 1'b0;
            end
            if (apb_wr && i_paddr == `HAT_CMD_OFS && state != S_IDLE) begin
                err <= 1'b1;
            end else if (apb_wr && i_paddr == `HAT_STATUS_OFS && i_pwdata[`HAT_STAT_ERR_BIT]) begin
                err <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            since_write <= 8'hFF;
            since_read  <= 8'hFF;
            last_read   <= T_BYTE_TEST;
        end else begin
            if (strobe_end && cmd.write && !dummy) begin
                since_write <= 8'h00;
            end else if (since_write != 8'hFF) begin
                since_write <= since_write + 8'h01;
            end
            if (strobe_end && !cmd.write && !dummy && cmd.target != T_BYTE_TEST) begin
                since_read <= 8'h00;
                last_read  <= cmd.target;
            end else if (since_read != 8'hFF) begin
                since_read <= since_read + 8'h01;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state     <= S_IDLE;
            pins      <= PINS_IDLE;
            cnt       <= 6'h00;
            dummy     <= 1'b0;
            dummy_cnt <= 8'h00;
            rdata     <= 16'h0000;
            o_data    <= 16'h0000;
            o_data_oe_n <= 1'b1;
        end else begin
            case (state)
                S_IDLE: begin
                    if (start) begin
                        state     <= S_WAIT;
                        dummy_cnt <= 8'h00;
                    end
                end
                S_WAIT: begin
                    cnt <= 6'h00;
                    // write framed by select and write strobe
                    if (cmd.write) begin
                        state       <= S_STROBE;
                        dummy       <= 1'b0;
                        pins        <= '{device_select_low: 1'b0, read_strobe_low: 1'b1,
                                         write_strobe_low: 1'b0, fifo_select: cmd.fifo_sel,
                                         addr: cmd.addr};
                        o_data      <= wdata;
                        o_data_oe_n <= 1'b0;
                    // read framed by select and read strobe
                    end else if (gap_met) begin
                        state <= S_STROBE;
                        dummy <= 1'b0;
                        pins  <= '{device_select_low: 1'b0, read_strobe_low: 1'b0,
                                   write_strobe_low: 1'b1, fifo_select: cmd.fifo_sel,
                                   addr: cmd.addr};
                    // fill the wait with a dummy read
                    end else if (ctrl[`HAT_CTRL_DUMMY_BIT]) begin
                        state     <= S_STROBE;
                        dummy     <= 1'b1;
                        dummy_cnt <= dummy_cnt + 8'h01;
                        pins      <= '{device_select_low: 1'b0, read_strobe_low: 1'b0,
                                       write_strobe_low: 1'b1, fifo_select: 1'b0,
                                       addr: BYTE_TEST_ADDR};
                    end
                end
                S_STROBE: begin
                    cnt <= cnt + 6'h01;
                    // end the access by releasing both strobes
                    if (strobe_end) begin
                        state       <= S_RECOVER;
                        cnt         <= 6'h00;
                        pins        <= PINS_IDLE;
                        o_data_oe_n <= 1'b1;
                        if (!cmd.write && !dummy) begin
                            rdata <= i_data;
                        end
                    end
                end
                S_RECOVER: begin
                    cnt <= cnt + 6'h01;
                    if (recover_end) begin
                        cnt   <= 6'h00;
                        state <= dummy ? S_WAIT : S_IDLE;
                        dummy <= 1'b0;
                    end
                end
                default: begin
                    state <= S_IDLE;
                    pins  <= PINS_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        hit      = 1'b1;
        o_prdata = 32'h0000_0000;
        case (i_paddr)
            `HAT_CTRL_OFS:   o_prdata = {30'h0, ctrl};
            `HAT_CMD_OFS:    o_prdata = {19'h0, cmd};
            `HAT_WDATA_OFS:  o_prdata = {16'h0, wdata};
            `HAT_RDATA_OFS:  o_prdata = {16'h0, rdata};
            `HAT_STATUS_OFS: begin
                o_prdata[`HAT_STAT_BUSY_BIT] = state != S_IDLE;
                o_prdata[`HAT_STAT_DONE_BIT] = done;
                o_prdata[`HAT_STAT_ERR_BIT]  = err;
                o_prdata[`HAT_STAT_DCNT_LSB +: 8] = dummy_cnt;
            end
            default:         hit = 1'b0;
        endcase
    end

    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel && i_penable && !hit;

    default clocking dflt @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);

    AST_READ_FRAME: assert property (
        !pins.read_strobe_low |-> !pins.device_select_low && pins.write_strobe_low
    ) else $error("read strobe without select or with write strobe");

    AST_WRITE_FRAME: assert property (
        $fell(pins.write_strobe_low) |-> !pins.device_select_low && !o_data_oe_n
            && o_data == wdata
    ) else $error("write strobe without select or data");

    AST_SLOW_GAP: assert property (
        $fell(pins.read_strobe_low) && !dummy && cmd.target == T_SLOW |-> since_write >= GAP2
    ) else $error("slow register read too soon after write");

    AST_ORDINARY_GAP: assert property (
        $fell(pins.read_strobe_low) && !dummy &&
        (cmd.target == T_GENERIC || cmd.target == T_TX_LVL || cmd.target == T_RECEIVE_DATAPATH_CONTROL_REG)
        |-> since_write >= GAP1
    ) else $error("register read too soon after write");

    AST_ZERO_WAIT: assert property (
        state == S_WAIT && !cmd.write && cmd.target == T_IDENTITY_REVISION_REG |=> $fell(pins.read_strobe_low)
    ) else $error("identity read delayed");

    AST_RX_LEVEL: assert property (
        $fell(pins.read_strobe_low) && !dummy && cmd.target == T_RX_LVL &&
        (last_read == T_RX_DATA || last_read == T_RX_STATUS) |-> since_read >= GAP1
    ) else $error("receive level read too soon");

    AST_TX_LEVEL: assert property (
        $fell(pins.read_strobe_low) && !dummy && cmd.target == T_TX_LVL &&
        last_read == T_TX_STATUS |-> since_read >= GAP1
    ) else $error("transmit level read too soon");

    AST_DROP_PAIR: assert property (
        $fell(pins.read_strobe_low) && !dummy && cmd.target == T_RX_DROP &&
        last_read == T_RX_DROP |-> since_read >= GAP2
    ) else $error("dropped counter reread too soon");

    AST_FFWD_HOLD: assert property (
        $fell(pins.read_strobe_low) && !dummy && ctrl[`HAT_CTRL_FFWD_BIT] &&
        last_read == T_RECEIVE_DATAPATH_CONTROL_REG && (cmd.target == T_RX_STATUS || cmd.target == T_TX_STATUS)
        |-> since_read >= GAP2
    ) else $error("status fifo read too soon after datapath control");

    AST_STROBE_WIDTH: assert property (
        $fell(pins.device_select_low) |-> (!pins.device_select_low)[*8] ##1 pins.device_select_low
    ) else $error("strobe width wrong");

    AST_DUMMY_TARGET: assert property (
        $fell(pins.read_strobe_low) && dummy |-> pins.addr == BYTE_TEST_ADDR && !pins.fifo_select
    ) else $error("dummy read not at byte-order test register");

    AST_RECOVERY: assert property (
        $rose(pins.device_select_low) |-> pins.device_select_low[*8]
    ) else $error("select reasserted too early");
endmodule
`default_nettype wire

// >>> rtl/hat_map.svh
// offsets, field positions, reset values and timing counts of the access sequencer
`ifndef HAT_MAP_SVH
`define HAT_MAP_SVH

`define HAT_CTRL_OFS        12'h000
`define HAT_CMD_OFS         12'h004
`define HAT_WDATA_OFS       12'h008
`define HAT_RDATA_OFS       12'h00C
`define HAT_STATUS_OFS      12'h010

`define HAT_CTRL_DUMMY_BIT  0
`define HAT_CTRL_FFWD_BIT   1
`define HAT_CTRL_RST        2'h0

`define HAT_CMD_ADDR_LSB    0
`define HAT_CMD_TGT_LSB     7
`define HAT_CMD_WRITE_BIT   11
`define HAT_CMD_FIFO_BIT    12

`define HAT_STAT_BUSY_BIT   0
`define HAT_STAT_DONE_BIT   1
`define HAT_STAT_ERR_BIT    2
`define HAT_STAT_DCNT_LSB   8

`define HAT_CLK_NS          4
`define HAT_T_GAP1_NS       165
`define HAT_T_GAP2_NS       330
`define HAT_T_ASSERT_NS     32
`define HAT_T_CYCLE_NS      165
`define HAT_T_DEASSERT_NS   13

`define HAT_CYC_GAP1    ((`HAT_T_GAP1_NS + `HAT_CLK_NS - 1) / `HAT_CLK_NS)
`define HAT_CYC_GAP2    ((`HAT_T_GAP2_NS + `HAT_CLK_NS - 1) / `HAT_CLK_NS)
`define HAT_CYC_ASSERT  ((`HAT_T_ASSERT_NS + `HAT_CLK_NS - 1) / `HAT_CLK_NS)
`define HAT_CYC_CYCLE   ((`HAT_T_CYCLE_NS + `HAT_CLK_NS - 1) / `HAT_CLK_NS)
`define HAT_CYC_RECOVER (`HAT_CYC_CYCLE - `HAT_CYC_ASSERT)

`endif

// >>> rtl/hat_pkg.sv
// types of the host access sequencer
`default_nettype none
package hat_pkg;
    typedef enum logic [3:0] {
        T_GENERIC    = 4'h0,
        T_IDENTITY_REVISION_REG     = 4'h1,
        T_BYTE_TEST  = 4'h2,
        T_RX_LVL     = 4'h3,
        T_RX_DROP    = 4'h4,
        T_TX_LVL     = 4'h5,
        T_RECEIVE_DATAPATH_CONTROL_REG = 4'h6,
        T_SLOW       = 4'h7,
        T_RX_DATA    = 4'h8,
        T_RX_STATUS  = 4'h9,
        T_TX_STATUS  = 4'hA,
        T_TX_DATA    = 4'hB
    } hat_target_t;

    typedef enum logic [1:0] {
        S_IDLE    = 2'b00,
        S_WAIT    = 2'b01,
        S_STROBE  = 2'b10,
        S_RECOVER = 2'b11
    } hat_state_t;

    typedef struct packed {
        logic        fifo_sel;
        logic        write;
        hat_target_t target;
        logic [6:0]  addr;
    } hat_cmd_t;

    typedef struct packed {
        logic       device_select_low;
        logic       read_strobe_low;
        logic       write_strobe_low;
        logic       fifo_select;
        logic [6:0] addr;
    } hat_pins_t;
endpackage
`default_nettype wire

// >>> test/hat_dev_model.sv
// behavioural model of the device side of the parallel host port
`default_nettype none
module hat_dev_model #(
    parameter logic [6:0] BT_ADDR = 7'h7F
) (
    input  wire logic               i_clock,
    input  wire logic               i_arst_n,
    input  wire hat_pkg::hat_pins_t i_pins,
    input  wire logic [15:0]        i_host_data,
    input  wire logic               i_host_oe_n,
    output logic      [15:0]        o_data,
    output logic      [31:0]        o_gap,
    output logic      [7:0]         o_dums,
    output logic      [15:0]        o_wr_data,
    output logic                    o_wr_fifo,
    output logic      [31:0]        o_min_low,
    output logic      [31:0]        o_min_cyc
);
    timeunit 1ns;
    timeprecision 1ps;
    import hat_pkg::*;
    logic [31:0] cyc, rel_t, start_t, low_n;
    logic [7:0]  dum_n;
    logic [15:0] last;
    logic        act, act_q, rd, dummy, cur_dum;
    // a cycle needs select and a strobe low
    assign act = !i_pins.device_select_low && (!i_pins.read_strobe_low || !i_pins.write_strobe_low);
    assign rd = !i_pins.device_select_low && !i_pins.read_strobe_low;
    assign dummy = rd && !i_pins.fifo_select && (i_pins.addr == BT_ADDR);
    // read data from address; released bus shows inverse of last word
    assign o_data = rd ? {4'hA, i_pins.fifo_select, i_pins.addr, 4'h5} : ~last;
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cyc       <= '0;
            act_q     <= 1'b0;
            rel_t     <= '0;
            start_t   <= '0;
            low_n     <= '0;
            dum_n     <= '0;
            last      <= '0;
            cur_dum   <= 1'b0;
            o_gap     <= '0;
            o_dums    <= '0;
            o_wr_data <= '0;
            o_wr_fifo <= 1'b0;
            o_min_low <= '1;
            o_min_cyc <= '1;
        end else begin
            cyc <= cyc + 1;
            act_q <= act;
            if (act) low_n <= low_n + 1;
            if (rd) last <= o_data;
            if (act && !act_q) begin
                if (start_t != 0 && (cyc - start_t) < o_min_cyc) o_min_cyc <= cyc - start_t;
                start_t <= cyc;
                low_n <= 32'h1;
                cur_dum <= dummy;
                if (dummy) dum_n <= dum_n + 1;
                else begin
                    dum_n <= '0;
                    if (rd) o_gap <= cyc - rel_t;
                    if (rd) o_dums <= dum_n;
                end
            end
            if (!act && act_q) begin
                if (low_n < o_min_low) o_min_low <= low_n;
                if (!cur_dum) rel_t <= cyc;
            end
            // write word taken while select and write strobe are low
            if (act && !i_pins.write_strobe_low && !i_host_oe_n) begin
                o_wr_data <= i_host_data;
                o_wr_fifo <= i_pins.fifo_select;
            end
        end
    end
endmodule
`default_nettype wire

// >>> test/host_access_hazard_timing_tb.sv
// self-checking bench of the host access sequencer
`default_nettype none
`include "hat_map.svh"
module host_access_hazard_timing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hat_pkg::*;
    logic        clock, arst_n, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, oe_n;
    hat_pins_t   pins;
    logic [15:0] hdata, ddata, wr_data;
    logic [31:0] gap, min_low, min_cyc, r;
    logic [7:0]  dums;
    logic        wr_fifo, e;
    int          n_fail, num_checks;

    hat_host #(.BYTE_TEST_ADDR(7'h7F)) i_dut (.i_clock(clock), .i_arst_n(arst_n),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_pins(pins), .o_data(hdata), .o_data_oe_n(oe_n), .i_data(ddata));
    hat_dev_model #(.BT_ADDR(7'h7F)) i_dev (.i_clock(clock), .i_arst_n(arst_n), .i_pins(pins),
        .i_host_data(hdata), .i_host_oe_n(oe_n), .o_data(ddata), .o_gap(gap), .o_dums(dums),
        .o_wr_data(wr_data), .o_wr_fifo(wr_fifo), .o_min_low(min_low), .o_min_cyc(min_cyc));

    always #2 clock = ~clock;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        logic rdy;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        // answer taken at the rising edge that samples pready high
        do begin
            @(posedge clock);
            rd  = prdata;
            er  = pslverr;
            rdy = pready;
        end while (rdy !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run(input logic w, input logic f, input hat_target_t t);
        int n;
        apb(1'b1, `HAT_CMD_OFS, {19'h0, f, w, t, t, 3'h0}, r, e);
        n = 0;
        do begin
            apb(1'b0, `HAT_STATUS_OFS, 32'h0, r, e);
            n++;
        end while (r[0] !== 1'b0 && n < 300);
        if (n >= 300) chk(32'h1, 32'h0);
    endtask

    task automatic chk_rdata(input logic f, input hat_target_t t);
        apb(1'b0, `HAT_RDATA_OFS, 32'h0, r, e);
        chk({16'h0, r[15:0]}, {16'h0, 4'hA, f, t, 3'h0, 4'h5});
    endtask

    task automatic t_reset;
        chk({21'h0, pins}, {21'h0, 1'b1, 1'b1, 1'b1, 1'b0, 7'h00});
        apb(1'b0, `HAT_CTRL_OFS, 32'h0, r, e);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h0);
        apb(1'b0, 12'h020, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        $display("test reset done");
    endtask

    task automatic t_write_fifo;
        apb(1'b1, `HAT_WDATA_OFS, 32'h5A3C, r, e);
        run(1'b1, 1'b1, T_TX_DATA);
        chk({16'h0, wr_data}, 32'h5A3C);
        chk({31'h0, wr_fifo}, 32'h1);
        run(1'b0, 1'b0, T_TX_LVL);
        chk({31'h0, gap >= 42}, 32'h1);
        chk_rdata(1'b0, T_TX_LVL);
        $display("test fifo write done");
    endtask

    task automatic t_write_gaps;
        hat_target_t tg[3] = '{T_GENERIC, T_TX_LVL, T_SLOW};
        int nd[3] = '{42, 42, 83};
        for (int i = 0; i < 3; i++) begin
            run(1'b1, 1'b0, T_GENERIC);
            run(1'b0, 1'b0, tg[i]);
            chk({31'h0, gap >= nd[i]}, 32'h1);
        end
        $display("test write gaps done");
    endtask

    task automatic t_dummy;
        hat_target_t tg[3] = '{T_IDENTITY_REVISION_REG, T_RX_LVL, T_RX_DROP};
        apb(1'b1, `HAT_CTRL_OFS, 32'h1, r, e);
        run(1'b1, 1'b0, T_GENERIC);
        run(1'b0, 1'b0, T_SLOW);
        chk({31'h0, gap >= 83}, 32'h1);
        chk({31'h0, dums != 0}, 32'h1);
        chk({31'h0, r[15:8] != 8'h00}, 32'h1);
        for (int i = 0; i < 3; i++) begin
            run(1'b1, 1'b0, T_GENERIC);
            run(1'b0, 1'b0, tg[i]);
            chk({24'h0, r[15:8]}, 32'h0);
            chk({24'h0, dums}, 32'h0);
        end
        apb(1'b1, `HAT_CTRL_OFS, 32'h0, r, e);
        $display("test dummy reads done");
    endtask

    task automatic t_read_pairs;
        hat_target_t t1[6] = '{T_RX_DATA, T_RX_STATUS, T_TX_STATUS, T_RX_DROP,
                               T_RECEIVE_DATAPATH_CONTROL_REG, T_RECEIVE_DATAPATH_CONTROL_REG};
        hat_target_t t2[6] = '{T_RX_LVL, T_RX_LVL, T_TX_LVL, T_RX_DROP,
                               T_RX_STATUS, T_TX_STATUS};
        int nd[6] = '{42, 42, 42, 83, 83, 83};
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, `HAT_CTRL_OFS, (i > 3) ? 32'h2 : 32'h0, r, e);
            run(1'b0, (i == 0), t1[i]);
            run(1'b0, 1'b0, t2[i]);
            chk({31'h0, gap >= nd[i]}, 32'h1);
            chk_rdata(1'b0, t2[i]);
        end
        $display("test read pairs done");
    endtask

    task automatic t_refuse;
        apb(1'b1, `HAT_CMD_OFS, {19'h0, 1'b0, 1'b1, T_GENERIC, 7'h00}, r, e);
        run(1'b0, 1'b0, T_IDENTITY_REVISION_REG);
        chk({30'h0, r[2:1]}, 32'h3);
        apb(1'b1, `HAT_STATUS_OFS, 32'h6, r, e);
        apb(1'b0, `HAT_STATUS_OFS, 32'h0, r, e);
        chk({29'h0, r[2:0]}, 32'h0);
        chk({31'h0, min_low >= 8}, 32'h1);
        chk({31'h0, min_cyc >= 42}, 32'h1);
        $display("test refusal and framing done");
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        $display("mismatch at %0t: timeout", $time);
        final_report();
    end

    initial begin
        clock      = 1'b0;
        arst_n     = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = '0;
        pwdata     = '0;
        n_fail     = 0;
        num_checks = 0;
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        t_reset();
        t_write_fifo();
        t_write_gaps();
        t_dummy();
        t_read_pairs();
        t_refuse();
        final_report();
    end
endmodule
`default_nettype wire
